// *** hw/pims_params.svh ***
// Constants for the periodic interrupt microframe scheduler.
// Assumes inclusion by bare name from the package and the scheduler.
`ifndef PIMS_PARAMS_SVH
`define PIMS_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define PIMS_ADR_CTRL      8'h00
`define PIMS_ADR_WORD_TWO  8'h04
`define PIMS_ADR_DW4_LO    8'h08
`define PIMS_ADR_DW4_HI    8'h0C
`define PIMS_ADR_DW5_LO    8'h10
`define PIMS_ADR_IRQ_STAT  8'h14
`define PIMS_ADR_IRQ_CLR   8'h18
`define PIMS_ADR_IRQ_EN    8'h1C
`define PIMS_ADR_STATE     8'h20

// Widths
`define PIMS_ADR_W         8
`define PIMS_DAT_W         32
`define PIMS_UF_NUM        8
`define PIMS_UF_IDX_W      3
`define PIMS_FRAME_W       5
`define PIMS_CNT_W         12
`define PIMS_RES_W         3
`define PIMS_CNT_FIELDS    3
`define PIMS_IRQ_W         3

// Descriptor word two: frame number field position
`define PIMS_FRAME_LSB     3
`define PIMS_FRAME_MSB     7

// Descriptor word four, low half: mask and result fields
`define PIMS_MASK_LSB      0
`define PIMS_MASK_MSB      7
`define PIMS_RES_BASE      8

// Descriptor word four, high half (bits 63..32 seen as 31..0)
`define PIMS_CNT0_LSB      0
`define PIMS_CNT0_MSB      11
`define PIMS_CNT1_LSB      12
`define PIMS_CNT1_MSB      23
`define PIMS_CNT2L_LSB     24
`define PIMS_CNT2L_MSB     31

// Descriptor word five: upper nibble of microframe 2 count
`define PIMS_CNT2H_LSB     0
`define PIMS_CNT2H_MSB     3

// Split point of the microframe 2 count
`define PIMS_CNT2_SPLIT    8

// Result bits
`define PIMS_RES_XACT_ERR  0
`define PIMS_RES_BABBLE    1
`define PIMS_RES_UNDERRUN  2

// Interrupt status bits
`define PIMS_IRQ_DONE      0
`define PIMS_IRQ_ERR       1
`define PIMS_IRQ_EMPTY     2

// Control bits
`define PIMS_CTRL_EN       0

// Reset values
`define PIMS_RST_WORD      32'h0000_0000
`define PIMS_RST_MASK      8'h00
`define PIMS_RST_CNT       12'h000
`define PIMS_RST_RES       3'h0
`define PIMS_RST_FRAME     5'h00
`define PIMS_RST_IRQ       3'h0

`endif

// *** hw/pims_pkg.sv ***
// Types shared by the scheduler and its bench.
// Assumes pims_params.svh is on the include path.
`include "pims_params.svh"

package pims_pkg;

  // Scheduler states
  typedef enum logic [0:0] {
    PIMS_IDLE,
    PIMS_BUSY
  } pims_state_t;

  // Microframe start event from the frame timer
  typedef struct packed {
    logic                          start;   // One-cycle pulse
    logic [`PIMS_UF_IDX_W-1:0]     uframe;  // Microframe index 0..7
    logic [`PIMS_FRAME_W-1:0]      frame;   // Current bus frame number
  } pims_sof_t;

  // Transaction request to the link engine
  typedef struct packed {
    logic                          req;     // One-cycle pulse
    logic [`PIMS_UF_IDX_W-1:0]     uframe;  // Microframe served
  } pims_req_t;

  // Transaction completion from the link engine
  typedef struct packed {
    logic                          done;    // One-cycle pulse
    logic [`PIMS_CNT_W-1:0]        bytes;   // Bytes received
    logic [`PIMS_RES_W-1:0]        result;  // Error, babble, underrun
  } pims_done_t;

endpackage : pims_pkg

// *** hw/pims_sched.sv ***
// Per-microframe scheduler for one periodic interrupt descriptor.
// Assumes a classic Wishbone master on mclk and a link engine on mclk
// that answers each request with exactly one done pulse.
`include "pims_params.svh"

module pims_sched (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [`PIMS_ADR_W-1:0]      wb_adr_i,
  input  wire logic [`PIMS_DAT_W-1:0]      wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  output logic      [`PIMS_DAT_W-1:0]      wb_dat_o,
  output logic                             wb_ack_o,
  input  wire pims_pkg::pims_sof_t         sof_i,
  output pims_pkg::pims_req_t              req_o,
  input  wire pims_pkg::pims_done_t        done_i,
  output logic                             irq_o
);

  // Software-visible state
  logic                         enable_q;       // Scheduler enable
  logic [`PIMS_FRAME_W-1:0]     frame_sel_q;    // Word two frame field
  logic [`PIMS_UF_NUM-1:0]      mask_q;         // Microframe select mask
  logic [`PIMS_UF_NUM-1:0]      mask_d;
  logic [`PIMS_RES_W-1:0]       res_q [`PIMS_UF_NUM];    // Per-microframe result
  logic [`PIMS_CNT_W-1:0]       cnt_q [`PIMS_CNT_FIELDS]; // Byte counts 0..2
  logic [`PIMS_IRQ_W-1:0]       irq_stat_q;     // Sticky events
  logic [`PIMS_IRQ_W-1:0]       irq_stat_d;
  logic [`PIMS_IRQ_W-1:0]       irq_en_q;       // Event enables

  // Scheduler state
  pims_pkg::pims_state_t        state_q;
  logic [`PIMS_UF_IDX_W-1:0]    cur_uf_q;       // Microframe in flight

  // Bus decode
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       bus_wr    = bus_req & wb_we_i;
  wire       bus_wr_b0 = bus_wr & wb_sel_i[0];
  wire       hit_ctrl  = (wb_adr_i == `PIMS_ADR_CTRL);
  wire       hit_two   = (wb_adr_i == `PIMS_ADR_WORD_TWO);
  wire       hit_dw4lo = (wb_adr_i == `PIMS_ADR_DW4_LO);
  wire       hit_dw4hi = (wb_adr_i == `PIMS_ADR_DW4_HI);
  wire       hit_dw5lo = (wb_adr_i == `PIMS_ADR_DW5_LO);
  wire       hit_ista  = (wb_adr_i == `PIMS_ADR_IRQ_STAT);
  wire       hit_iclr  = (wb_adr_i == `PIMS_ADR_IRQ_CLR);
  wire       hit_ien   = (wb_adr_i == `PIMS_ADR_IRQ_EN);
  wire       hit_state = (wb_adr_i == `PIMS_ADR_STATE);

  // Mask bits that software requests in this cycle
  wire [`PIMS_UF_NUM-1:0] sw_set =
    (bus_wr_b0 & hit_dw4lo) ? wb_dat_i[`PIMS_MASK_MSB:`PIMS_MASK_LSB]
                            : `PIMS_RST_MASK;

  // Frame match gates every mask lookup
  wire frame_match = (frame_sel_q == sof_i.frame);

  // Launch when the mask bit of the starting microframe is set
  wire mask_hit = mask_q[sof_i.uframe];
  wire launch   = enable_q & sof_i.start & frame_match & mask_hit &
                  (state_q == pims_pkg::PIMS_IDLE);

  // Completion of the transaction in flight
  wire finish   = done_i.done & (state_q == pims_pkg::PIMS_BUSY);

  // Mask bit cleared by hardware on write-back
  wire [`PIMS_UF_NUM-1:0] hw_clr =
    finish ? (`PIMS_UF_NUM'(1) << cur_uf_q) : `PIMS_RST_MASK;

  // Events for the interrupt logic
  wire       ev_err   = finish & (|done_i.result);
  wire       ev_empty = finish & ((mask_q & ~hw_clr) == `PIMS_RST_MASK);
  wire [`PIMS_IRQ_W-1:0] ev_vec = {ev_empty, ev_err, finish};
  wire [`PIMS_IRQ_W-1:0] irq_clr =
    (bus_wr_b0 & hit_iclr) ? wb_dat_i[`PIMS_IRQ_W-1:0] : `PIMS_RST_IRQ;

  // Next mask: a software set wins over a same-cycle hardware clear
  always_comb
  begin
    mask_d = (mask_q & ~hw_clr) | sw_set;
  end

  // Next interrupt status: a new event wins over a clear
  always_comb
  begin
    irq_stat_d = (irq_stat_q & ~irq_clr) | ev_vec;
  end

  // Assembled descriptor views
  logic [`PIMS_DAT_W-1:0] dw4_lo;   // Results and mask
  logic [`PIMS_DAT_W-1:0] dw4_hi;   // Counts 0, 1 and low byte of 2
  logic [`PIMS_DAT_W-1:0] dw5_lo;   // High nibble of count 2

  // Result fields, three bits per microframe from bit 8 upward
  assign dw4_lo[`PIMS_MASK_MSB:`PIMS_MASK_LSB] = mask_q;
  genvar g;
  generate
    for (g = 0; g < `PIMS_UF_NUM; g++)
    begin : g_res
      assign dw4_lo[`PIMS_RES_BASE + g*`PIMS_RES_W +: `PIMS_RES_W] = res_q[g];
    end
  endgenerate

  // Count fields in the upper descriptor half
  assign dw4_hi[`PIMS_CNT0_MSB:`PIMS_CNT0_LSB]   = cnt_q[0];
  assign dw4_hi[`PIMS_CNT1_MSB:`PIMS_CNT1_LSB]   = cnt_q[1];
  assign dw4_hi[`PIMS_CNT2L_MSB:`PIMS_CNT2L_LSB] =
    cnt_q[2][`PIMS_CNT2_SPLIT-1:0];
  assign dw5_lo = {{(`PIMS_DAT_W-`PIMS_CNT2H_MSB-1){1'b0}},
                   cnt_q[2][`PIMS_CNT_W-1:`PIMS_CNT2_SPLIT]};

  // Read multiplexer; unmapped and write-only read as zero
  wire [`PIMS_DAT_W-1:0] rd_data =
    hit_ctrl  ? {{(`PIMS_DAT_W-1){1'b0}}, enable_q} :
    hit_two   ? {{(`PIMS_DAT_W-`PIMS_FRAME_MSB-1){1'b0}}, frame_sel_q,
                 {`PIMS_FRAME_LSB{1'b0}}} :
    hit_dw4lo ? dw4_lo :
    hit_dw4hi ? dw4_hi :
    hit_dw5lo ? dw5_lo :
    hit_ista  ? {{(`PIMS_DAT_W-`PIMS_IRQ_W){1'b0}}, irq_stat_q} :
    hit_ien   ? {{(`PIMS_DAT_W-`PIMS_IRQ_W){1'b0}}, irq_en_q} :
    hit_state ? {{(`PIMS_DAT_W-`PIMS_UF_IDX_W-1){1'b0}}, cur_uf_q,
                 (state_q == pims_pkg::PIMS_BUSY)} :
                `PIMS_RST_WORD;

  // Bus answer: ack one cycle after the request, dropped the next
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PIMS_RST_WORD;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : `PIMS_RST_WORD;
    end
  end

  // Control and word two registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_q    <= 1'b0;
      frame_sel_q <= `PIMS_RST_FRAME;
    end
    else
    begin
      if (bus_wr_b0 && hit_ctrl)
        enable_q <= wb_dat_i[`PIMS_CTRL_EN];
      if (bus_wr_b0 && hit_two)
        frame_sel_q <= wb_dat_i[`PIMS_FRAME_MSB:`PIMS_FRAME_LSB];
    end
  end

  // Mask register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= `PIMS_RST_MASK;
    else
      mask_q <= mask_d;
  end

  // Result write-back, only for the microframe just served
  generate
    for (g = 0; g < `PIMS_UF_NUM; g++)
    begin : g_res_q
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          res_q[g] <= `PIMS_RST_RES;
        else if (finish && cur_uf_q == `PIMS_UF_IDX_W'(g))
          res_q[g] <= done_i.result;
      end
    end
  endgenerate

  // Count write-back for microframes that own a count field
  generate
    for (g = 0; g < `PIMS_CNT_FIELDS; g++)
    begin : g_cnt_q
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cnt_q[g] <= `PIMS_RST_CNT;
        else if (finish && cur_uf_q == `PIMS_UF_IDX_W'(g))
          cnt_q[g] <= done_i.bytes;
      end
    end
  endgenerate

  // Scheduler: one transaction in flight at a time
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q  <= pims_pkg::PIMS_IDLE;
      cur_uf_q <= `PIMS_UF_IDX_W'(0);
    end
    else
    begin
      unique case (state_q)
        pims_pkg::PIMS_IDLE:
        begin
          // Start when this microframe is selected
          if (launch)
          begin
            state_q  <= pims_pkg::PIMS_BUSY;
            cur_uf_q <= sof_i.uframe;
          end
        end
        pims_pkg::PIMS_BUSY:
        begin
          // Wait for the link engine to finish
          if (finish)
            state_q <= pims_pkg::PIMS_IDLE;
        end
      endcase
    end
  end

  // Request pulse toward the link engine
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_o.req    <= 1'b0;
      req_o.uframe <= `PIMS_UF_IDX_W'(0);
    end
    else
    begin
      req_o.req <= launch;
      if (launch)
        req_o.uframe <= sof_i.uframe;
    end
  end

  // Interrupt status, enable and output
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_stat_q <= `PIMS_RST_IRQ;
      irq_en_q   <= `PIMS_RST_IRQ;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (bus_wr_b0 && hit_ien)
        irq_en_q <= wb_dat_i[`PIMS_IRQ_W-1:0];
      irq_o <= |(irq_stat_d & ((bus_wr_b0 && hit_ien) ?
                 wb_dat_i[`PIMS_IRQ_W-1:0] : irq_en_q));
    end
  end

endmodule : pims_sched

// *** bench/pims_sched_checker.sv ***
// Port-level assertions for the microframe scheduler.
// Assumes one clock, mclk, and async active-low rstn.
`include "pims_params.svh"

module pims_sched_checker (
  input wire logic                  mclk,
  input wire logic                  rstn,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire pims_pkg::pims_sof_t   sof_i,
  input wire pims_pkg::pims_req_t   req_o,
  input wire pims_pkg::pims_done_t  done_i,
  input wire logic                  irq_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Request pending and not yet answered
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // Launch seen one cycle after the start pulse
  sequence s_launch;
    sof_i.start ##1 req_o.req;
  endsequence

  AST_ACK_NEXT: assert property (s_wb_req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  AST_REQ_CAUSE: assert property (req_o.req |-> $past(sof_i.start))
    else $error("transaction request without start");
  AST_REQ_UF: assert property (s_launch |-> req_o.uframe == $past(sof_i.uframe))
    else $error("request carries wrong microframe");
  AST_REQ_PULSE: assert property (req_o.req |=> !req_o.req [*2])
    else $error("request not a single pulse");
  AST_REQ_HOLD: assert property (!req_o.req |-> $stable(req_o.uframe))
    else $error("request microframe moved while idle");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |->
      $past(done_i.done) || $past(done_i.done, 2) || $past(wb_cyc_i && wb_we_i))
    else $error("interrupt rose without cause");
endmodule : pims_sched_checker

bind pims_sched pims_sched_checker u_chk (.mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .sof_i, .req_o, .done_i, .irq_o);

// *** bench/pims_link_model.sv ***
// Link engine model: one done pulse per request.
// Assumes requests only while idle; lat_i sets the answer delay.
module pims_link_model (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire pims_pkg::pims_req_t  req_i,
  input  wire logic [3:0]           lat_i,
  output pims_pkg::pims_done_t      done_o
);
  logic [3:0]  wait_q;  // Cycles left before done
  logic        busy_q;  // Transaction in flight
  logic [2:0]  uf_q;    // Microframe served
  logic        live;    // Done this cycle
  logic [11:0] bytes;   // Byte count for this microframe
  logic [2:0]  res;     // Result code for this microframe

  // Delay counter started by each request
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      uf_q   <= 3'h0;
    end
    else if (req_i.req)
    begin
      busy_q <= 1'b1;
      wait_q <= lat_i;
      uf_q   <= req_i.uframe;
    end
    else if (busy_q && wait_q == 4'h0)
      busy_q <= 1'b0;
    else if (busy_q)
      wait_q <= wait_q - 4'h1;
  end

  // Outside the done pulse the data lines show the inverse
  assign live   = busy_q && wait_q == 4'h0;
  assign bytes  = 12'h3C0 | {9'h000, uf_q};
  assign res    = uf_q ^ 3'h5;
  assign done_o = '{live, live ? bytes : ~bytes, live ? res : ~res};
endmodule : pims_link_model

// *** bench/pims_sched_tb_top.sv ***
// Self-checking bench for the scheduler over Wishbone.
// Assumes the link model and bound checker are compiled first.
`include "pims_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module pims_sched_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]           wb_adr_i;
  logic [31:0]          wb_dat_i, wb_dat_o, rd;
  logic [3:0]           wb_sel_i, lat;
  pims_pkg::pims_sof_t  sof_i;
  pims_pkg::pims_req_t  req_o;
  pims_pkg::pims_done_t done_i;
  int                   miscompares, checks_done, reqs, cyc_cnt;

  pims_sched uut (.mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .sof_i, .req_o, .done_i, .irq_o);
  pims_link_model u_link (.mclk, .rstn, .req_i(req_o), .lat_i(lat), .done_o(done_i));

  // Free-running clock, 20 ns period
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Request counter and hang guard
  always @(posedge mclk)
  begin
    cyc_cnt++;
    if (req_o.req === 1'b1)
      reqs++;
    if (cyc_cnt == 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // One classic Wishbone cycle, held until ack; only the hang guard ends a wait
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
    do
    begin
      @(posedge mclk);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge mclk);
  endtask : wb_cycle

  // Read and compare
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb_cycle(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask : chk_rd

  // Start pulse for one microframe, then let the transfer finish
  task automatic uf_start(input logic [2:0] u, input logic [4:0] f);
    @(posedge mclk);
    sof_i <= '{1'b1, u, f};
    @(posedge mclk);
    sof_i.start <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask : uf_start

  // Result fields expected for a served mask
  function automatic logic [31:0] res_word(input logic [7:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 8; i++)
      if (m[i])
        r[8+3*i +: 3] = i[2:0] ^ 3'h5;
    return r;
  endfunction : res_word

  // Print counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    sof_i = '0;
    rstn = 1'b0;
    lat = 4'h1;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    chk_rd("mask reset", `PIMS_ADR_DW4_LO, 32'h0000_0000);
    chk_rd("unmapped", 8'h24, 32'h0000_0000);
    wb_cycle(1'b1, `PIMS_ADR_CTRL, 32'h0000_0001);
    wb_cycle(1'b1, `PIMS_ADR_WORD_TWO, 32'h0000_0028);
    wb_cycle(1'b1, `PIMS_ADR_IRQ_EN, 32'h0000_0007);
    wb_cycle(1'b1, `PIMS_ADR_DW4_LO, 32'h0000_0005);
    uf_start(3'h0, 5'h04);
    `CHK("req frame mismatch", 0, reqs)
    for (int i = 0; i < 8; i++)
      uf_start(i[2:0], 5'h05);
    `CHK("req sparse mask", 2, reqs)
    chk_rd("results sparse", `PIMS_ADR_DW4_LO, res_word(8'h05));
    chk_rd("counts sparse", `PIMS_ADR_DW4_HI, 32'hC200_03C0);
    chk_rd("cnt2 upper", `PIMS_ADR_DW5_LO, 32'h0000_0003);
    `CHK("irq raised", 1'b1, irq_o)
    chk_rd("irq status", `PIMS_ADR_IRQ_STAT, 32'h0000_0007);
    wb_cycle(1'b1, `PIMS_ADR_IRQ_CLR, 32'h0000_0007);
    `CHK("irq cleared", 1'b0, irq_o)
    wb_cycle(1'b1, `PIMS_ADR_IRQ_EN, 32'h0000_0000);
    lat = 4'h6;
    wb_cycle(1'b1, `PIMS_ADR_DW4_LO, 32'h0000_00FF);
    for (int i = 0; i < 8; i++)
      uf_start(i[2:0], 5'h05);
    `CHK("req full mask", 10, reqs)
    `CHK("irq masked", 1'b0, irq_o)
    wb_cycle(1'b1, `PIMS_ADR_IRQ_EN, 32'h0000_0007);
    `CHK("irq unmasked", 1'b1, irq_o)
    chk_rd("results full", `PIMS_ADR_DW4_LO, res_word(8'hFF));
    chk_rd("counts full", `PIMS_ADR_DW4_HI, 32'hC23C_13C0);
    wrap_up();
  end
endmodule : pims_sched_tb_top
